/* File: src/obti_defines.svh */
// constants for the ofdm bit and tone interleaver
`ifndef OBTI_DEFINES_SVH
`define OBTI_DEFINES_SVH
`define OBTI_NENC        8
`define OBTI_ENC_W       7
`define OBTI_BLK_BITS    48
`define OBTI_GRP_EQ      6
`define OBTI_GRP_HI      7
`define OBTI_GRP_LO      5
`define OBTI_LO_BASE     28
`define OBTI_HALF_BLK    24
`define OBTI_SYM_GRP     360
`define OBTI_NFFT        512
`define OBTI_IDX_W       9
`define OBTI_KFIRST      (-188)
`define OBTI_KLAST       188
`define OBTI_NULL_EDGE   190
`define OBTI_PILOT_FIRST 14
`define OBTI_PILOT_STEP  25
`define OBTI_PILOT_LAST  189
`define OBTI_CP_LEN      64
`define OBTI_LTS_REPS    2
`define OBTI_SAMP_W      16
`endif

/* File: src/obti_pkg.sv */
// types shared by the bit and tone interleaver
package obti_pkg;
  typedef enum logic [1:0] {MODE_EQUAL, MODE_UNEQ_CODE, MODE_UNEQ_MAP} obti_mode_t;
  typedef enum logic [1:0] {RATE_4_7, RATE_2_3, RATE_4_5, RATE_1_3} obti_rate_t;
endpackage : obti_pkg

/* File: src/obti_bits_if.sv */
// carrier between the top and the bit interleaver
`timescale 1ns/10ps
`include "obti_defines.svh"
interface obti_bits_if;
  logic [`OBTI_BLK_BITS-1:0] mux_blk;
  logic [`OBTI_BLK_BITS-1:0] ilv_blk;
  obti_pkg::obti_mode_t      mode;
  modport top (output mux_blk, output mode, input ilv_blk);
  modport ilv (input mux_blk, input mode, output ilv_blk);
endinterface : obti_bits_if

/* File: src/obti_bit_ilv.sv */
// 48-bit block interleaver for the three multiplex modes
`timescale 1ns/10ps
`include "obti_defines.svh"
module obti_bit_ilv (
  obti_bits_if.ilv b
);
  logic [`OBTI_BLK_BITS-1:0] eq_blk;
  logic [`OBTI_BLK_BITS-1:0] map_blk;

  // fixed permutations, one wire per input position
  for (genvar x = 0; x < `OBTI_BLK_BITS; x++) begin : g_perm
    localparam int BASE = 6 * (x / 6) - 5 * (x % 6) + 5 * `OBTI_BLK_BITS;
    localparam int YEQ  = BASE % `OBTI_BLK_BITS;
    localparam int YMAP = 2 * (BASE % `OBTI_HALF_BLK) + ((x >= `OBTI_HALF_BLK) ? 1 : 0);
    assign eq_blk[YEQ]   = b.mux_blk[x];
    assign map_blk[YMAP] = b.mux_blk[x];
  end

  // map mode puts encoders a-d on even (i) and e-h on odd (q) positions
  assign b.ilv_blk = (b.mode == obti_pkg::MODE_UNEQ_MAP) ? map_blk : eq_blk;
endmodule : obti_bit_ilv

/* File: src/obti_top.sv */
// ofdm multiplexer, bit interleaver, symbol padder, tone placer and midamble sequencer
// Contract
// - equal mode takes six bits per encoder, a first, a at positions 0..5.
// - equal mode permutes block by y=(6*floor(x/6)-5*(x mod 6)) mod 48.
// - unequal coding runs encoders a-d at rate 4/7, e-h at 4/5.
// - unequal coding takes seven bits from a-d, five from e-h.
// - unequal coding: a at 0..6, e starts 28, f starts 33.
// - unequal coding uses the same 48-bit permutation as equal mode.
// - unequal mapping shares one rate; a-d to i branch, e-h to q.
// - unequal mapping takes six bits per encoder, h at 42..47.
// - unequal mapping doubles the mod-24 permutation, plus one for upper half.
// - symbols are zero-padded up to a multiple of 360.
// - tones -256..255; beyond 189 null; -1,0,1 are dc.
// - pilots at plus and minus 14+25m up to 189; rest carry data.
// - each 360-symbol group fills data tones -188 to 188 in order.
// - tone interleaver reverses the nine-bit tone index over all 512 tones.
// - pilot, dc and null tones sit at bit-reversed slots before interleaving.
// - midamble is 64-sample cyclic prefix then two long training sequences.
`timescale 1ns/10ps
`include "obti_defines.svh"
module obti_top #(
  parameter int SAMP_W = `OBTI_SAMP_W
) (
  // clock, reset, enable
  input  wire logic                                      clk,
  input  wire logic                                      arst_n,
  input  wire logic                                      ce,
  // frame control
  input  wire logic                                      frame_start,
  input  wire obti_pkg::obti_mode_t                      mode_sel,
  input  wire obti_pkg::obti_rate_t                      shared_rate,
  // encoder side
  input  wire logic                                      enc_valid,
  input  wire logic [`OBTI_NENC-1:0][`OBTI_ENC_W-1:0]    enc_bits,
  output logic [`OBTI_NENC-1:0][1:0]                     enc_rate_q,
  output logic                                           blk_valid_q,
  output logic [`OBTI_BLK_BITS-1:0]                      blk_q,
  // mapped symbols in
  input  wire logic                                      sym_valid,
  input  wire logic                                      sym_last,
  input  wire logic [SAMP_W-1:0]                         sym_re,
  input  wire logic [SAMP_W-1:0]                         sym_im,
  input  wire logic [SAMP_W-1:0]                         pilot_re,
  output logic                                           sym_ready_q,
  // interleaved tones out
  output logic                                           tone_valid_q,
  output logic [`OBTI_IDX_W-1:0]                         tone_idx_q,
  output logic [SAMP_W-1:0]                              tone_re_q,
  output logic [SAMP_W-1:0]                              tone_im_q,
  // midamble sequencer
  input  wire logic                                      mid_req,
  output logic                                           mid_valid_q,
  output logic [`OBTI_IDX_W-1:0]                         mid_idx_q
);
  localparam int IW = `OBTI_IDX_W;
  typedef enum logic [1:0] {ST_FILL, ST_PAD, ST_EMIT} obti_state_t;

  obti_bits_if bi ();
  obti_bit_ilv u_ilv (.b(bi));

  // tone classification on a signed subcarrier number
  function automatic logic is_pilot(input logic signed [IW:0] k);
    int a;
    a = (k < 0) ? -int'(k) : int'(k);
    return a >= `OBTI_PILOT_FIRST && a <= `OBTI_PILOT_LAST && (a - `OBTI_PILOT_FIRST) % `OBTI_PILOT_STEP == 0;
  endfunction : is_pilot
  function automatic logic is_ctrl(input logic signed [IW:0] k);
    int a;
    a = (k < 0) ? -int'(k) : int'(k);
    return a >= `OBTI_NULL_EDGE || a <= 1 || is_pilot(k);
  endfunction : is_ctrl
  function automatic logic [IW-1:0] bitrev(input logic [IW-1:0] v);
    for (int j = 0; j < IW; j++) bitrev[j] = v[IW-1-j];
  endfunction : bitrev

  // multiplex state
  obti_pkg::obti_mode_t              mode_q, mode_d;
  logic [`OBTI_BLK_BITS-1:0]         mux_blk;
  logic [`OBTI_NENC-1:0][1:0]        rate_d;

  // group multiplexer, one slot for each of the six low bits of every encoder
  for (genvar e = 0; e < `OBTI_NENC; e++) begin : g_mux
    for (genvar j = 0; j < `OBTI_GRP_EQ; j++) begin : g_bit
      localparam int PEQ = `OBTI_GRP_EQ * e + j;
      assign mux_blk[PEQ] = (mode_q != obti_pkg::MODE_UNEQ_CODE) ? enc_bits[e][j] : 1'b0;
    end
  end

  // unequal coding layout overlays the six-bit layout
  logic [`OBTI_BLK_BITS-1:0] uc_blk;
  for (genvar p = 0; p < `OBTI_BLK_BITS; p++) begin : g_uc_pos
    localparam int E = (p < `OBTI_LO_BASE) ? p / `OBTI_GRP_HI : 4 + (p - `OBTI_LO_BASE) / `OBTI_GRP_LO;
    localparam int J = (p < `OBTI_LO_BASE) ? p % `OBTI_GRP_HI : (p - `OBTI_LO_BASE) % `OBTI_GRP_LO;
    assign uc_blk[p] = enc_bits[E][J];
  end
  assign bi.mux_blk = (mode_q == obti_pkg::MODE_UNEQ_CODE) ? uc_blk : mux_blk;
  assign bi.mode    = mode_q;

  // mode latch and per-encoder rate selection
  always_comb begin
    mode_d = frame_start ? mode_sel : mode_q;
    for (int e = 0; e < `OBTI_NENC; e++) begin
      if (mode_d == obti_pkg::MODE_UNEQ_CODE) begin
        rate_d[e] = (e < 4) ? 2'(obti_pkg::RATE_4_7) : 2'(obti_pkg::RATE_4_5);
      end else begin
        rate_d[e] = 2'(shared_rate);
      end
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q      <= obti_pkg::MODE_EQUAL;
      enc_rate_q  <= '0;
      blk_valid_q <= 1'b0;
      blk_q       <= '0;
    end else if (ce) begin
      mode_q      <= mode_d;
      enc_rate_q  <= rate_d;
      blk_valid_q <= enc_valid;
      blk_q       <= enc_valid ? bi.ilv_blk : blk_q;
    end
  end

  // tone buffer indexed by fft bin (k mod 512)
  logic [2*SAMP_W-1:0] tone_mem [`OBTI_NFFT];
  obti_state_t         st_q, st_d;
  logic [IW-1:0]       n_q, n_d;       // symbol count in group
  logic signed [IW:0]  k_q, k_d;       // next data subcarrier
  logic [IW-1:0]       i_q, i_d;       // output tone index
  logic                wr_en;
  logic [2*SAMP_W-1:0] wr_val;
  logic signed [IW:0]  k_step;
  logic [IW-1:0]       src_bin;
  logic signed [IW:0]  out_k;

  // next data tone skipping pilots and dc; at most three control tones in a row (dc)
  always_comb begin
    k_step = k_q + (IW+1)'(1);
    for (int s = 0; s < 3; s++) begin
      if (is_ctrl(k_step) && k_step < `OBTI_KLAST) k_step = k_step + (IW+1)'(1);
    end
  end

  // fill, pad and emit sequencing
  always_comb begin
    st_d   = st_q;
    n_d    = n_q;
    k_d    = k_q;
    i_d    = i_q;
    wr_en  = 1'b0;
    wr_val = '0;
    case (st_q)
      ST_FILL, ST_PAD: begin
        if (st_q == ST_PAD || sym_valid) begin
          wr_en  = 1'b1;
          wr_val = (st_q == ST_PAD) ? '0 : {sym_re, sym_im};
          n_d    = n_q + 1'b1;
          k_d    = k_step;
          if (st_q == ST_FILL && sym_last) st_d = ST_PAD;
          if (n_q == IW'(`OBTI_SYM_GRP - 1)) begin
            st_d = ST_EMIT;
            n_d  = '0;
            k_d  = (IW+1)'(`OBTI_KFIRST);
            i_d  = '0;
          end
        end
      end
      ST_EMIT: begin
        i_d = i_q + 1'b1;
        if (i_q == IW'(`OBTI_NFFT - 1)) st_d = ST_FILL;
      end
      default: st_d = ST_FILL;
    endcase
  end

  // output slot i carries what sat at bin bitrev(i) before interleaving
  always_comb begin
    src_bin = bitrev(i_q);
    out_k   = $signed({i_q[IW-1], i_q});
  end

  always_ff @(posedge clk) begin
    if (ce && wr_en) tone_mem[k_q[IW-1:0]] <= wr_val;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q         <= ST_FILL;
      n_q          <= '0;
      k_q          <= (IW+1)'(`OBTI_KFIRST);
      i_q          <= '0;
      sym_ready_q  <= 1'b0;
      tone_valid_q <= 1'b0;
      tone_idx_q   <= '0;
      tone_re_q    <= '0;
      tone_im_q    <= '0;
    end else if (ce) begin
      st_q         <= st_d;
      n_q          <= n_d;
      k_q          <= k_d;
      i_q          <= i_d;
      sym_ready_q  <= (st_d == ST_FILL);
      tone_valid_q <= (st_q == ST_EMIT);
      tone_idx_q   <= i_q;
      if (st_q == ST_EMIT) begin
        // control tones land on their nominal bin; data reads bit-reversed bin
        if (is_pilot(out_k)) begin
          tone_re_q <= pilot_re;
          tone_im_q <= '0;
        end else if (is_ctrl(out_k) || is_ctrl($signed({src_bin[IW-1], src_bin}))) begin
          tone_re_q <= '0;
          tone_im_q <= '0;
        end else begin
          tone_re_q <= tone_mem[src_bin][2*SAMP_W-1:SAMP_W];
          tone_im_q <= tone_mem[src_bin][SAMP_W-1:0];
        end
      end
    end
  end

  // midamble: prefix is the last 64 samples, then two full sequences
  localparam int MID_LEN = `OBTI_CP_LEN + `OBTI_LTS_REPS * `OBTI_NFFT;
  logic [10:0] mc_q, mc_d;
  logic        ma_q, ma_d;
  always_comb begin
    ma_d = ma_q;
    mc_d = mc_q;
    if (!ma_q && mid_req) begin
      ma_d = 1'b1;
      mc_d = '0;
    end else if (ma_q) begin
      mc_d = mc_q + 1'b1;
      if (mc_q == 11'(MID_LEN - 1)) ma_d = 1'b0;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ma_q        <= 1'b0;
      mc_q        <= '0;
      mid_valid_q <= 1'b0;
      mid_idx_q   <= '0;
    end else if (ce) begin
      ma_q        <= ma_d;
      mc_q        <= mc_d;
      mid_valid_q <= ma_q;
      mid_idx_q   <= (mc_q < 11'(`OBTI_CP_LEN)) ? IW'(mc_q + 11'(`OBTI_NFFT - `OBTI_CP_LEN))
                                                 : IW'(mc_q - 11'(`OBTI_CP_LEN));
    end
  end

  // checks
  a_uc_rates: assert property (@(posedge clk) disable iff (!arst_n)
    ce && mode_q == obti_pkg::MODE_UNEQ_CODE && !frame_start |=> enc_rate_q[0] == 2'(obti_pkg::RATE_4_7)
      && enc_rate_q[7] == 2'(obti_pkg::RATE_4_5)) else $error("unequal coding rates wrong");
  a_mode_hold: assert property (@(posedge clk) disable iff (!arst_n)
    ce && !frame_start |=> $stable(mode_q)) else $error("mode changed inside frame");
  a_blk_eq_a0: assert property (@(posedge clk) disable iff (!arst_n)
    ce && enc_valid && mode_q == obti_pkg::MODE_EQUAL |=> blk_q[0] == $past(enc_bits[0][0]))
    else $error("equal block bit 0 wrong");
  // last bit of encoder h sits at input 47 and leaves on odd output 35
  a_blk_map_h: assert property (@(posedge clk) disable iff (!arst_n)
    ce && enc_valid && mode_q == obti_pkg::MODE_UNEQ_MAP |=> blk_q[35] == $past(enc_bits[7][5]))
    else $error("map block bit 35 wrong");
  // first bit of encoder e sits at input 28 and leaves on output 4
  a_blk_uc_e: assert property (@(posedge clk) disable iff (!arst_n)
    ce && enc_valid && mode_q == obti_pkg::MODE_UNEQ_CODE |=> blk_q[4] == $past(enc_bits[4][0]))
    else $error("coding block bit 4 wrong");
  a_emit_len: assert property (@(posedge clk) disable iff (!arst_n)
    ce && st_q == ST_EMIT && i_q == '0 |-> st_q == ST_EMIT [*8]) else $error("emit ended early");
  a_fill_k: assert property (@(posedge clk) disable iff (!arst_n)
    wr_en |-> !is_ctrl(k_q)) else $error("data written to control tone");
  a_pad_zero: assert property (@(posedge clk) disable iff (!arst_n)
    st_q == ST_PAD |-> wr_en && wr_val == '0) else $error("pad symbol not zero");
  a_grp_done: assert property (@(posedge clk) disable iff (!arst_n)
    ce && wr_en && n_q == 9'h167 |=> st_q == ST_EMIT) else $error("group of 360 not closed");
  a_mid_cp: assert property (@(posedge clk) disable iff (!arst_n)
    ce && ma_q && mc_q == '0 |=> mid_idx_q == 9'h1c0) else $error("prefix start index wrong");
  a_null_out: assert property (@(posedge clk) disable iff (!arst_n)
    ce && st_q == ST_EMIT && i_q == 9'h100 |=> tone_re_q == '0 && tone_im_q == '0)
    else $error("null tone not zero");
  c_uc_block: cover property (@(posedge clk) ce && enc_valid && mode_q == obti_pkg::MODE_UNEQ_CODE);
  c_pad:      cover property (@(posedge clk) st_q == ST_PAD ##1 st_q == ST_EMIT);
  c_emit:     cover property (@(posedge clk) st_q == ST_EMIT && i_q == 9'h1ff);
  c_mid:      cover property (@(posedge clk) ma_q && mc_q == 11'h43f);
endmodule : obti_top

/* File: bench/obti_enc_model.sv */
// behavioural model of the eight parallel convolutional encoders
`timescale 1ns/10ps
`include "obti_defines.svh"
module obti_enc_model (
  // clock
  input  wire logic                                clk,
  // coded bits towards the multiplexer
  output logic                                     enc_valid,
  output logic [`OBTI_NENC-1:0][`OBTI_ENC_W-1:0]   enc_bits
);
  // quiet lines until the first cycle
  initial begin
    enc_valid = 1'b0;
    enc_bits  = '0;
  end

  // one multiplexing cycle of coded bits, held across the taking edge, then inverted
  task automatic send(input logic [`OBTI_NENC-1:0][`OBTI_ENC_W-1:0] bits);
    @(negedge clk);
    enc_valid = 1'b1;
    enc_bits  = bits;
    @(negedge clk);
    enc_valid = 1'b0;
    enc_bits  = ~bits; // stale bits must not leak into the next block
  endtask : send
endmodule : obti_enc_model

/* File: bench/testbench.sv */
// self-checking bench for the bit and tone interleaver
`timescale 1ns/10ps
`include "obti_defines.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module testbench;
  localparam logic [15:0] PILOT = 16'h3a5c;
  logic                                   clk, arst_n, ce, frame_start, enc_valid, blk_valid_q;
  logic                                   sym_valid, sym_last, sym_ready_q, tone_valid_q, mid_req, mid_valid_q;
  obti_pkg::obti_mode_t                   mode_sel;
  obti_pkg::obti_rate_t                   shared_rate;
  logic [`OBTI_NENC-1:0][`OBTI_ENC_W-1:0] enc_bits;
  logic [`OBTI_NENC-1:0][1:0]             enc_rate_q;
  logic [`OBTI_BLK_BITS-1:0]              blk_q;
  logic [15:0]                            sym_re, sym_im, pilot_re, tone_re_q, tone_im_q;
  logic [`OBTI_IDX_W-1:0]                 tone_idx_q, mid_idx_q;
  int                                     fail_count, tests_run;
  int                                     dtab [512];

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  obti_enc_model u_enc (.clk(clk), .enc_valid(enc_valid), .enc_bits(enc_bits));
  obti_top dut (.clk(clk), .arst_n(arst_n), .ce(ce), .frame_start(frame_start), .mode_sel(mode_sel),
    .shared_rate(shared_rate), .enc_valid(enc_valid), .enc_bits(enc_bits), .enc_rate_q(enc_rate_q),
    .blk_valid_q(blk_valid_q), .blk_q(blk_q), .sym_valid(sym_valid), .sym_last(sym_last), .sym_re(sym_re),
    .sym_im(sym_im), .pilot_re(pilot_re), .sym_ready_q(sym_ready_q), .tone_valid_q(tone_valid_q),
    .tone_idx_q(tone_idx_q), .tone_re_q(tone_re_q), .tone_im_q(tone_im_q), .mid_req(mid_req),
    .mid_valid_q(mid_valid_q), .mid_idx_q(mid_idx_q));

  // signed subcarrier of a bin, tone class (0 data, 1 pilot, 2 null or dc), bit reversal
  function automatic int sc_of(input int b);
    return (b >= 256) ? b - 512 : b;
  endfunction : sc_of
  function automatic int kind_of(input int sc);
    int a;
    a = (sc < 0) ? -sc : sc;
    if (a >= `OBTI_NULL_EDGE || a <= 1) return 2;
    if (a >= 14 && (a - 14) % 25 == 0) return 1;
    return 0;
  endfunction : kind_of
  function automatic int bitrev(input int k);
    int r;
    r = 0;
    for (int j = 0; j < 9; j++) r = (r << 1) | ((k >> j) & 1);
    return r;
  endfunction : bitrev
  // block permutation, folded into halves for the mapping mode
  function automatic int perm(input int x, input bit split);
    int y;
    y = 6 * (x / 6) - 5 * (x % 6);
    if (!split) return ((y % 48) + 48) % 48;
    return 2 * (((y % 24) + 24) % 24) + ((x >= 24) ? 1 : 0);
  endfunction : perm

  // walks a single set bit over all 48 block inputs with the unused encoder bits held high
  task automatic run_mode(input obti_pkg::obti_mode_t m);
    int e, j, x;
    logic [`OBTI_NENC-1:0][`OBTI_ENC_W-1:0] base, bits;
    logic [`OBTI_BLK_BITS-1:0]              exp_blk;
    logic [1:0]                             exp_rate;
    @(negedge clk);
    mode_sel    = m;
    frame_start = 1'b1;
    @(negedge clk);
    frame_start = 1'b0;
    for (e = 0; e < 8; e++) base[e] = (m != obti_pkg::MODE_UNEQ_CODE) ? 7'h40 : (e < 4) ? 7'h00 : 7'h60;
    for (x = 0; x < 48; x++) begin
      e = (m != obti_pkg::MODE_UNEQ_CODE) ? x / 6 : (x < 28) ? x / 7 : 4 + (x - 28) / 5;
      j = (m != obti_pkg::MODE_UNEQ_CODE) ? x % 6 : (x < 28) ? x % 7 : (x - 28) % 5;
      bits       = base;
      bits[e][j] = 1'b1;
      exp_blk    = '0;
      exp_blk[perm(x, m == obti_pkg::MODE_UNEQ_MAP)] = 1'b1;
      u_enc.send(bits);
      `CHK(blk_valid_q, 1'b1)
      `CHK(blk_q, exp_blk)
    end
    for (e = 0; e < 8; e++) begin
      exp_rate = (m != obti_pkg::MODE_UNEQ_CODE) ? shared_rate : (e < 4) ? obti_pkg::RATE_4_7 : obti_pkg::RATE_4_5;
      `CHK(enc_rate_q[e], exp_rate)
    end
  endtask : run_mode

  // sends cnt symbols, then checks the 512 interleaved tones of the padded group
  task automatic run_group(input int cnt);
    int          n, w, i, b;
    logic [15:0] er, ei;
    w = 0;
    while (sym_ready_q !== 1'b1 && w < 1000) begin
      @(negedge clk);
      w++;
    end
    `CHK(sym_ready_q, 1'b1)
    for (n = 0; n < cnt; n++) begin
      @(negedge clk);
      sym_valid = 1'b1;
      sym_last  = (n == cnt - 1);
      sym_re    = 16'(n + 1);
      sym_im    = 16'h8000 | 16'(n);
    end
    @(negedge clk);
    sym_valid = 1'b0;
    sym_last  = 1'b0;
    sym_re    = ~sym_re;
    sym_im    = ~sym_im;
    w = 0;
    while (tone_valid_q !== 1'b1 && w < 1000) begin
      @(negedge clk);
      w++;
    end
    for (n = 0; n < 512; n++) begin
      i  = n;
      b  = bitrev(i);
      er = '0;
      ei = '0;
      if (kind_of(sc_of(i)) == 1) er = PILOT;
      else if (kind_of(sc_of(i)) == 0 && kind_of(sc_of(b)) == 0 && dtab[b] < cnt) begin
        er = 16'(dtab[b] + 1);
        ei = 16'h8000 | 16'(dtab[b]);
      end
      `CHK(tone_valid_q, 1'b1)
      `CHK(tone_idx_q, 9'(n))
      `CHK({tone_re_q, tone_im_q}, {er, ei})
      @(negedge clk);
    end
    `CHK(tone_valid_q, 1'b0)
  endtask : run_group

  // midamble index run: cyclic prefix tail, then two full training sequences
  task automatic run_mid();
    int j;
    @(negedge clk);
    mid_req = 1'b1;
    @(negedge clk);
    mid_req = 1'b0;
    @(negedge clk);
    for (j = 0; j < 1088; j++) begin
      `CHK(mid_valid_q, 1'b1)
      `CHK(mid_idx_q, 9'((j < 64) ? 448 + j : (j - 64) % 512))
      // a low enable must freeze the sequence in place
      if (j == 100) begin
        ce = 1'b0;
        repeat (3) begin
          @(negedge clk);
          `CHK(mid_valid_q, 1'b1)
          `CHK(mid_idx_q, 9'h024)
        end
        ce = 1'b1;
      end
      @(negedge clk);
    end
    `CHK(mid_valid_q, 1'b0)
  endtask : run_mid

  // prints the counts and the verdict, then ends the run
  task automatic conclude();
    $display("checks run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  // hang guard, far beyond the few thousand cycles the tests need
  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    conclude();
  end

  // main sequence
  initial begin
    int sc, n;
    fail_count  = 0;
    tests_run   = 0;
    arst_n      = 1'b0;
    ce          = 1'b1;
    frame_start = 1'b0;
    mode_sel    = obti_pkg::MODE_EQUAL;
    shared_rate = obti_pkg::RATE_2_3;
    sym_valid   = 1'b0;
    sym_last    = 1'b0;
    sym_re      = '0;
    sym_im      = '0;
    pilot_re    = PILOT;
    mid_req     = 1'b0;
    n = 0;
    for (sc = -188; sc <= 188; sc++) begin
      if (kind_of(sc) == 0) begin
        dtab[(sc + 512) % 512] = n;
        n++;
      end
    end
    repeat (3) @(negedge clk);
    `CHK({blk_valid_q, tone_valid_q, mid_valid_q}, 3'b000)
    arst_n = 1'b1;
    repeat (2) @(negedge clk);
    run_mode(obti_pkg::MODE_EQUAL);
    run_mode(obti_pkg::MODE_UNEQ_CODE);
    run_mode(obti_pkg::MODE_UNEQ_MAP);
    run_group(5);
    run_group(360);
    run_mid();
    conclude();
  end
endmodule : testbench
